/* hdl/tx_path_defines.vh */
// constants for the transmit data path
`ifndef TX_PATH_DEFINES_VH
`define TX_PATH_DEFINES_VH
// ==========================
// register byte addresses
`define ADDR_TX_BYTE      12'h000
`define ADDR_TX_FIFO_CTRL 12'h004
`define ADDR_MODE_CTRL    12'h008
`define ADDR_IRQ_STATUS   12'h00C
`define ADDR_IRQ_MASK     12'h010
`define ADDR_SHIFT_STATUS 12'h014
// ==========================
// transmit fifo control fields
`define FFEN_BIT     14
`define TXRST_BIT    13
`define FILL_HI      12
`define FILL_LO      8
`define INT_BIT      7
`define INTCLR_BIT   6
`define IENA_BIT     5
`define LEVEL_HI     4
`define LEVEL_LO     0
// ==========================
// mode control fields
`define BITCNT_HI    2
`define BITCNT_LO    0
`define TXEN_BIT     3
// ==========================
// interrupt status bits
`define EV_FIFO_BIT  0
`define EV_DONE_BIT  1
`define EV_WIDTH     2
// ==========================
// reset values and widths
`define BYTE_RESET   8'h00
`define CTRL_RESET   16'h0000
`define MODE_RESET   4'h0
`define FIFO_DEPTH   16
`define FILL_W       5
`endif

/* hdl/tx_fifo_store.v */
// flip-flop storage for the transmit fifo
`timescale 1ns/1ps
`default_nettype none
module tx_fifo_store #(
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire          pclk,
  input  wire          presetn,
  input  wire          clear,
  input  wire          push,
  input  wire [7:0]    push_data,
  input  wire          pop,
  output wire [7:0]    head_data,
  output reg  [AW:0]   count_reg
);
  // ==========================
  // storage
  reg [7:0]    mem_reg [0:DEPTH-1];
  reg [AW-1:0] wr_reg;
  reg [AW-1:0] rd_reg;
  wire         do_push = push && (count_reg != DEPTH[AW:0]);
  wire         do_pop  = pop && (count_reg != {(AW+1){1'b0}});
  assign head_data = mem_reg[rd_reg];
  always @(posedge pclk) begin
    if (do_push) begin
      mem_reg[wr_reg] <= push_data;
    end
  end
  // pointers forced to zero while held in reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_reg    <= {AW{1'b0}};
      rd_reg    <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else if (clear) begin
      wr_reg    <= {AW{1'b0}};
      rd_reg    <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
      if (do_push && !do_pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (do_pop && !do_push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // tx_fifo_store
`default_nettype wire

/* hdl/tx_data_path.v */
// transmit data path with holding register, fifo and serial shifter
// Contract
// RULE1 - the transmit byte holds 1 to 8 bits and the shift width comes from bits_per_byte.
// RULE2 - software sets bits_per_byte first and right-justifies short bytes.
// RULE3 - a written byte is copied into a hidden transmit shift register.
// RULE4 - the shift register is sent on the serial data line one bit at a time.
// RULE5 - in transmit fifo mode writes to the transmit byte register push into the fifo.
// RULE6 - bits 15 to 8 of the transmit byte register read zero, bits 7 to 0 reset to zero.
// RULE7 - bit 14 of the fifo control register enables fifo mode globally; the code also needs bit 13 high for fifo mode.
// RULE8 - bit 13 low holds the transmit fifo in reset with pointer zero, high lets it run.
// RULE9 - bits 12 to 8 report the fifo fill count, 0 to 16.
// RULE10 - the irq flag sets as soon as the fifo is enabled since the count starts at zero.
// RULE11 - software should clear the flag once right after enabling the fifo.
// RULE12 - bit 7 is the read-only irq flag, cleared only by writing the clear bit.
// RULE13 - the flag sets whenever the fill count is at or below the level in bits 4 to 0.
// RULE14 - writing 1 to bit 6 clears the flag, writing 0 does nothing, reads return 0.
// RULE15 - bit 5 enables the flag onto the interrupt.
// RULE16 - each load of the shift register from the fifo pops one entry.
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "tx_path_defines.vh"
module tx_data_path #(
  parameter DEPTH = `FIFO_DEPTH
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        scl_in,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe_n,
  output reg         irq
);
  // ==========================
  // pin synchronisers
  reg  [1:0] scl_sync_reg;
  reg  [1:0] sda_sync_reg;
  reg        scl_prev_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_sync_reg <= 2'b11;
      sda_sync_reg <= 2'b11;
      scl_prev_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_prev_reg <= scl_sync_reg[1];
    end
  end
  // data changes while the link clock is low
  wire scl_fall = scl_prev_reg && !scl_sync_reg[1];
  // ==========================
  // register storage
  reg  [7:0]           tx_byte_reg;
  reg                  byte_full_reg;
  reg                  ffen_reg;
  reg                  txrst_reg;
  reg                  ienable_reg;
  reg  [4:0]           level_reg;
  reg                  flag_reg;
  reg  [3:0]           mode_reg;
  reg  [`EV_WIDTH-1:0] ev_status_reg;
  reg  [`EV_WIDTH-1:0] ev_mask_reg;
  wire [`FILL_W-1:0]   fill_count;
  wire [7:0]           fifo_head;
  // ==========================
  // apb decode; one wait state, writes land at the edge that sees pready high
  wire access   = psel && penable && !pready;
  wire wr_acc   = psel && penable && pready && pwrite;
  wire wr_byte  = wr_acc && (paddr == `ADDR_TX_BYTE);
  wire wr_ctrl  = wr_acc && (paddr == `ADDR_TX_FIFO_CTRL);
  wire wr_mode  = wr_acc && (paddr == `ADDR_MODE_CTRL);
  wire wr_stat  = wr_acc && (paddr == `ADDR_IRQ_STATUS);
  wire wr_mask  = wr_acc && (paddr == `ADDR_IRQ_MASK);
  wire mapped   = (paddr == `ADDR_TX_BYTE) || (paddr == `ADDR_TX_FIFO_CTRL) ||
                  (paddr == `ADDR_MODE_CTRL) || (paddr == `ADDR_IRQ_STATUS) ||
                  (paddr == `ADDR_IRQ_MASK) || (paddr == `ADDR_SHIFT_STATUS);
  wire fifo_mode = ffen_reg && txrst_reg; // RULE7
  // ==========================
  // shifter state
  localparam ST_IDLE  = 2'b00;
  localparam ST_SHIFT = 2'b01;
  localparam ST_DONE  = 2'b10;
  reg  [1:0] state_reg;
  reg  [7:0] shift_reg;
  reg  [3:0] bits_left_reg;
  wire [3:0] width = (mode_reg[`BITCNT_HI:`BITCNT_LO] == 3'h0) ? 4'h8 :
                     {1'b0, mode_reg[`BITCNT_HI:`BITCNT_LO]}; // RULE1
  wire have_data = fifo_mode ? (fill_count != {`FILL_W{1'b0}}) : byte_full_reg;
  wire load = (state_reg == ST_IDLE) && mode_reg[`TXEN_BIT] && have_data;
  wire pop  = load && fifo_mode; // RULE16
  // ==========================
  // transmit fifo
  tx_fifo_store #(
    .DEPTH (DEPTH),
    .AW    (`FILL_W-1)
  ) u_store (
    .pclk      (pclk),
    .presetn   (presetn),
    .clear     (!txrst_reg),                   // RULE8
    .push      (wr_byte && fifo_mode),         // RULE5
    .push_data (pwdata[7:0]),
    .pop       (pop),
    .head_data (fifo_head),
    .count_reg (fill_count)
  );
  // ==========================
  // registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_byte_reg   <= `BYTE_RESET;
      byte_full_reg <= 1'b0;
      ffen_reg      <= 1'b0;
      txrst_reg     <= 1'b0;
      ienable_reg   <= 1'b0;
      level_reg     <= 5'h00;
      mode_reg      <= `MODE_RESET;
      ev_mask_reg   <= {`EV_WIDTH{1'b0}};
    end else begin
      if (wr_byte && !fifo_mode) begin
        tx_byte_reg   <= pwdata[7:0]; // RULE6
        byte_full_reg <= 1'b1;
      end else if (load && !fifo_mode) begin
        byte_full_reg <= 1'b0;
      end
      if (wr_ctrl) begin
        ffen_reg    <= pwdata[`FFEN_BIT];
        txrst_reg   <= pwdata[`TXRST_BIT];
        ienable_reg <= pwdata[`IENA_BIT];
        level_reg   <= pwdata[`LEVEL_HI:`LEVEL_LO];
      end
      if (wr_mode) begin
        mode_reg <= pwdata[`TXEN_BIT:`BITCNT_LO];
      end
      if (wr_mask) begin
        ev_mask_reg <= pwdata[`EV_WIDTH-1:0];
      end
    end
  end
  // ==========================
  // fifo level flag; a set condition wins over the clear
  wire level_hit = fifo_mode && (fill_count <= level_reg); // RULE13 RULE10
  wire flag_clr  = wr_ctrl && pwdata[`INTCLR_BIT]; // RULE14
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= 1'b0;
    end else if (level_hit) begin
      flag_reg <= 1'b1;
    end else if (flag_clr) begin
      flag_reg <= 1'b0; // RULE12
    end
  end
  // ==========================
  // serial shifter, msb first
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg     <= ST_IDLE;
      shift_reg     <= 8'h00;
      bits_left_reg <= 4'h0;
      sda_out       <= 1'b1;
      sda_oe_n      <= 1'b1;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          sda_oe_n <= 1'b1;
          if (load) begin
            // align short bytes to the top so the msb goes first
            shift_reg     <= (fifo_mode ? fifo_head : tx_byte_reg) << (4'h8 - width); // RULE3
            bits_left_reg <= width;
            state_reg     <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (scl_fall) begin
            if (bits_left_reg == 4'h0) begin
              sda_oe_n  <= 1'b1;
              state_reg <= ST_DONE;
            end else begin
              sda_out       <= shift_reg[7]; // RULE4
              sda_oe_n      <= 1'b0;
              shift_reg     <= {shift_reg[6:0], 1'b0};
              bits_left_reg <= bits_left_reg - 4'h1;
            end
          end
        end
        ST_DONE: begin
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
  // ==========================
  // event status, write one to clear, set wins
  wire [`EV_WIDTH-1:0] ev_set;
  assign ev_set[`EV_FIFO_BIT] = flag_reg && ienable_reg; // RULE15
  assign ev_set[`EV_DONE_BIT] = (state_reg == ST_DONE);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_status_reg <= {`EV_WIDTH{1'b0}};
      irq           <= 1'b0;
    end else begin
      ev_status_reg <= ev_set |
                       (ev_status_reg & ~(wr_stat ? pwdata[`EV_WIDTH-1:0] : {`EV_WIDTH{1'b0}}));
      irq           <= |(ev_status_reg & ev_mask_reg);
    end
  end
  // ==========================
  // read mux
  reg [31:0] rdata_next;
  always @* begin
    rdata_next = 32'h0000_0000;
    case (paddr)
      `ADDR_TX_BYTE:      rdata_next = {24'h00_0000, tx_byte_reg}; // RULE6
      `ADDR_TX_FIFO_CTRL: rdata_next = {17'h0_0000, ffen_reg, txrst_reg, fill_count, // RULE9
                                        flag_reg, 1'b0, ienable_reg, level_reg};
      `ADDR_MODE_CTRL:    rdata_next = {28'h000_0000, mode_reg};
      `ADDR_IRQ_STATUS:   rdata_next = {30'h0000_0000, ev_status_reg};
      `ADDR_IRQ_MASK:     rdata_next = {30'h0000_0000, ev_mask_reg};
      `ADDR_SHIFT_STATUS: rdata_next = {26'h000_0000, bits_left_reg, state_reg};
      default:            rdata_next = 32'h0000_0000;
    endcase
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= access;
      pslverr <= access && !mapped;
      prdata  <= access ? rdata_next : 32'h0000_0000;
    end
  end
endmodule // tx_data_path
`default_nettype wire

/* test/tx_path_asserts.sv */
// port assertions for the transmit data path
`timescale 1ns/1ps
`default_nettype none
`include "tx_path_defines.vh"
module tx_path_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe_n,
  input wire logic        irq
);
  // ====================
  // apb and link checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd_ctrl = pready && !pwrite && paddr == `ADDR_TX_FIFO_CTRL;
  wire rd_tx   = pready && !pwrite && paddr == `ADDR_TX_BYTE;
  AST_ANSWER: assert property (psel && penable && !pready |=> pready) else $error("late answer");
  AST_PULSE: assert property (pready |=> !pready) else $error("pready held");
  AST_TX_RSVD: assert property (rd_tx |-> prdata[31:8] == 0) else $error("tx high bits");
  AST_CTRL_RSVD: assert property (rd_ctrl |-> prdata[31:15] == 0) else $error("ctrl bit15");
  AST_CLR_READ0: assert property (rd_ctrl |-> !prdata[6]) else $error("clear bit read");
  AST_FILL_MAX: assert property (rd_ctrl |-> prdata[12:8] <= 5'h10) else $error("fill");
  AST_HELD: assert property (rd_ctrl && !prdata[13] |-> prdata[12:8] == 0) else $error("held");
  AST_UNMAPPED: assert property (pready && paddr > 12'h014 |-> pslverr && prdata == 0)
    else $error("unmapped answer");
  // bits only move after a synchronised falling link edge, never while the clock is high
  AST_BIT_EDGE: assert property ($changed(sda_out) && !sda_oe_n |-> !$past(scl_in, 2))
    else $error("bit moved with clock high");
  AST_DRIVE_EDGE: assert property ($fell(sda_oe_n) |-> !$past(scl_in, 2))
    else $error("drive started off edge");
  COV_FIFO_FULLER: cover property (rd_ctrl && prdata[12:8] == 5'h02);
  COV_FLAG: cover property (rd_ctrl && prdata[7]);
  COV_SHIFT: cover property ($fell(sda_oe_n));
endmodule // tx_path_asserts
bind tx_data_path tx_path_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .irq(irq));
`default_nettype wire

/* test/i2c_far_end.sv */
// far-side model: link clock source and bit collector
`timescale 1ns/1ps
`default_nettype none
module i2c_far_end (
  input  wire logic sda_out,
  input  wire logic sda_oe_n,
  output var  logic scl,
  output wire logic sda
);
  logic [7:0] cap = 8'h00;
  // pull-up: a released line reads high, never the last bit
  assign sda = sda_oe_n ? 1'b1 : sda_out;
  // clock stands high outside frames
  initial scl = 1'b1;
  task frame(input int n);
    // step off the pclk edge grid so no link edge lands on a sampling edge
    #1.25;
    repeat (n) begin
      #32 scl = 1'b0;
      #32 scl = 1'b1;
    end
  endtask
  always @(posedge scl) if (!sda_oe_n) cap <= {cap[6:0], sda};
endmodule // i2c_far_end
`default_nettype wire

/* test/testbench.sv */
// self-checking bench for the transmit data path
`timescale 1ns/1ps
`default_nettype none
`include "tx_path_defines.vh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fail_count++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module testbench;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  wire  [31:0] prdata;
  wire         pready, pslverr, scl, sda, sda_out, sda_oe_n, irq;
  int          fail_count = 0, n_compared = 0;
  tx_data_path DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .irq(irq));
  i2c_far_end FE (.sda_out(sda_out), .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda));
  always #2.5 pclk = ~pclk;
  task finish_test;
    if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ====================
  // apb master
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    i = 0;
    do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin fail_count++; finish_test; end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d); apb(a, 1'b1, d); endtask
  task rc(input logic [11:0] a, input logic [31:0] e); apb(a, 1'b0, 0); `CHK(rd, e) endtask
  task push2; wr(`ADDR_TX_BYTE, 32'h0000_00a5); wr(`ADDR_TX_BYTE, 32'h0000_003c); endtask
  // ====================
  // main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    rc(`ADDR_TX_BYTE, 0);
    rc(`ADDR_TX_FIFO_CTRL, 0);
    rc(12'h020, 0);
    `CHK(err, 1'b1)
    // short byte: width 3, right-justified, high register bits ignored
    wr(`ADDR_MODE_CTRL, 32'h0000_000b);
    wr(`ADDR_TX_BYTE, 32'h0000_ff05);
    rc(`ADDR_TX_BYTE, 32'h0000_0005);
    FE.frame(4);
    `CHK(FE.cap[2:0], 3'b101)
    wr(`ADDR_MODE_CTRL, 0);
    wr(`ADDR_TX_FIFO_CTRL, 32'h0000_6020);
    rc(`ADDR_TX_FIFO_CTRL, 32'h0000_60a0);
    push2;
    wr(`ADDR_TX_FIFO_CTRL, 32'h0000_4020);
    apb(`ADDR_TX_FIFO_CTRL, 1'b0, 0);
    `CHK(rd[12:8], 5'h00)
    wr(`ADDR_TX_FIFO_CTRL, 32'h0000_6020);
    push2;
    wr(`ADDR_TX_FIFO_CTRL, 32'h0000_6060);
    rc(`ADDR_TX_FIFO_CTRL, 32'h0000_6220);
    wr(`ADDR_MODE_CTRL, 32'h0000_0008);
    rc(`ADDR_TX_FIFO_CTRL, 32'h0000_6120);
    rc(`ADDR_SHIFT_STATUS, 32'h0000_0021);
    FE.frame(9);
    `CHK(FE.cap, 8'ha5)
    rc(`ADDR_TX_FIFO_CTRL, 32'h0000_60a0);
    FE.frame(9);
    `CHK(FE.cap, 8'h3c)
    rc(`ADDR_SHIFT_STATUS, 32'h0000_0000);
    rc(`ADDR_IRQ_STATUS, 32'h0000_0003);
    wr(`ADDR_IRQ_MASK, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    `CHK(irq, 1'b1)
    wr(`ADDR_TX_FIFO_CTRL, 32'h0000_6000);
    wr(`ADDR_IRQ_STATUS, 32'h0000_0003);
    repeat (3) @(posedge pclk);
    `CHK(irq, 1'b0)
    rc(`ADDR_IRQ_STATUS, 32'h0000_0000);
    finish_test;
  end
endmodule // testbench
`default_nettype wire
